// ===== sbc_baud_gen.sv
// oversampling tick generator driven by the bit-rate code
`timescale 1ns/1ps
module sbc_baud_gen
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // rate code
  input wire logic [3:0] i_rate_code,
  // tick out
  output logic o_tick16
);

  // ==========================================================================
  // divisor table
  logic [15:0] div_tab [16];
  logic [15:0] cnt_r;
  logic [15:0] div_sel;
  logic wrap;

  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_div
      assign div_tab[g] = sbc_divisor(g);
    end
  endgenerate

  assign div_sel = div_tab[i_rate_code];
  assign wrap = (cnt_r >= div_sel - 16'h0001);

  // ==========================================================================
  // counter; code zero never ticks
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || i_rate_code == SBC_RATE_OFF)
    begin
      cnt_r <= 16'h0000;
      o_tick16 <= 1'b0;
    end
    else
    begin
      cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
      o_tick16 <= wrap;
    end
  end

endmodule : sbc_baud_gen

// ===== sbc_core.sv
// serial bridge configuration registers with the serial framing they steer
// Behaviour
// - misc bit 2 set raises a request on each manual request key press.
// - misc bit 1 set raises a request when autodisconnect stops traffic.
// - misc bit 0 set raises a request when a break is received.
// - requests reach the loop only while the master request bit is one.
// - frame bit 3 picks one or two stop bits, both directions.
// - frame bits 2:1 pick eight, seven, six or five data bits.
// - with marking and parity on, bad-parity bytes get top bit forced one.
// - rate code picks bit rate from 50 up to 19200 bps.
// - rate code zero stops all transmit and receive.
// - rate register resets to code 1110, 9600 bps.
// - parity/echo bits 3:2 pick odd, even, forced one or forced zero.
// - parity present adds a transmitted parity bit and expects one.
// - parity absent means no parity bit; all middle bits are data.
// - echo bit set retransmits each received character at once.
// - frame and parity/echo registers reset to zero.
// - listener command then data bytes load registers from index zero.
// - register bytes on the loop are value plus 48.
`timescale 1ns/1ps
module sbc_core
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // loop register access
  input wire logic i_local_mode,
  input wire logic i_wr_start,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_rd_start,
  input wire logic i_rd_req,
  output logic [7:0] o_rd_byte,
  output logic o_rd_valid,
  // loop data path
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  output logic o_tx_ready,
  output logic [7:0] o_rx_byte,
  output logic o_rx_valid,
  // service request
  input wire logic i_manual_request_key,
  input wire logic i_autodisconnect,
  input wire logic i_srq_clear,
  output logic o_srq,
  output sbc_req_t o_req_pending,
  // serial pins
  input wire logic i_rxd,
  output logic o_txd
);

  // ==========================================================================
  // register file
  logic [3:0] regs_r [SBC_NREGS];
  logic [3:0] wr_ptr_r;
  logic [3:0] rd_ptr_r;
  logic wr_armed_r;
  logic wr_hit;
  logic rd_hit;
  sbc_frame_cfg_t cfg;
  logic master_en;
  logic [3:0] misc_en;
  logic rate_off;

  assign wr_hit = i_local_mode && wr_armed_r && i_wr_valid
                  && wr_ptr_r <= SBC_REG_LAST;
  assign rd_hit = i_local_mode && i_rd_req && rd_ptr_r <= SBC_REG_LAST;
  assign master_en = regs_r[SBC_REG_PRIMARY][SBC_MASTER_BIT];
  assign misc_en = regs_r[SBC_REG_MISC];
  assign rate_off = (regs_r[SBC_REG_RATE] == SBC_RATE_OFF);
  assign cfg = {regs_r[SBC_REG_FRAME][SBC_FRAME_STOP],
                regs_r[SBC_REG_FRAME][SBC_FRAME_LEN_HI:SBC_FRAME_LEN_LO],
                regs_r[SBC_REG_FRAME][SBC_FRAME_MARK],
                regs_r[SBC_REG_PAREC][SBC_PAREC_SEL_HI:SBC_PAREC_SEL_LO],
                regs_r[SBC_REG_PAREC][SBC_PAREC_PRESENT],
                regs_r[SBC_REG_PAREC][SBC_PAREC_ECHO]};

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      for (int i = 0; i < SBC_NREGS; i++)
      begin
        regs_r[i] <= (i == int'(SBC_REG_RATE)) ? SBC_RATE_RESET
                                               : SBC_REG_RESET;
      end
    end
    else if (wr_hit)
      regs_r[wr_ptr_r] <= i_wr_byte[3:0];
  end

  // write pointer restarts at zero on each listener command
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      wr_armed_r <= 1'b0;
      wr_ptr_r <= 4'h0;
    end
    else if (i_wr_start && i_local_mode)
    begin
      wr_armed_r <= 1'b1;
      wr_ptr_r <= 4'h0;
    end
    else if (wr_hit)
      wr_ptr_r <= wr_ptr_r + 4'h1;
  end

  // read back, one byte per request
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      rd_ptr_r <= 4'h0;
      o_rd_byte <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= rd_hit;
      if (i_rd_start)
        rd_ptr_r <= 4'h0;
      else if (rd_hit)
      begin
        rd_ptr_r <= rd_ptr_r + 4'h1;
        o_rd_byte <= SBC_ASCII_OFFSET | {4'h0, regs_r[rd_ptr_r]};
      end
    end
  end

  // ==========================================================================
  // bit-rate ticks
  logic tick;

  sbc_baud_gen u_baud (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_rate_code(regs_r[SBC_REG_RATE]),
    .o_tick16(tick)
  );

  // ==========================================================================
  // receiver
  sbc_state_t rx_st_r;
  logic [3:0] rx_tick_r;
  logic [2:0] rx_idx_r;
  logic [7:0] rx_data_r;
  logic rx_par_r;
  logic rx_zero_r;
  logic rx_stop2_r;
  logic rxd_prev_r;
  logic rx_mid;
  logic rx_fin;
  logic rx_brk;
  logic rx_perr;
  logic rx_mark;
  logic echo_set;

  assign rx_mid = tick && rx_tick_r == SBC_MID_BIT;
  assign rx_fin = rx_st_r == SBC_ST_STOP && rx_mid && !rx_stop2_r;
  assign rx_brk = rx_zero_r && !i_rxd;
  assign rx_perr = cfg.par_en
                   && rx_par_r != sbc_parity(rx_data_r, cfg.len_code,
                                             cfg.par_sel);
  assign rx_mark = cfg.mark_perr && rx_perr;
  assign echo_set = rx_fin && !rx_brk && cfg.echo;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || rate_off)
    begin
      rx_st_r <= SBC_ST_IDLE;
      rx_tick_r <= 4'h0;
      rx_idx_r <= 3'h0;
      rx_data_r <= 8'h00;
      rx_par_r <= 1'b0;
      rx_zero_r <= 1'b0;
      rx_stop2_r <= 1'b0;
      rxd_prev_r <= 1'b1;
    end
    else
    begin
      rxd_prev_r <= i_rxd;
      if (rx_st_r != SBC_ST_IDLE && tick)
        rx_tick_r <= rx_tick_r + 4'h1;
      case (rx_st_r)
        SBC_ST_IDLE:
          if (rxd_prev_r && !i_rxd)
          begin
            rx_st_r <= SBC_ST_START;
            rx_tick_r <= 4'h0;
          end
        SBC_ST_START:
          if (tick && rx_tick_r == SBC_MID_START)
          begin
            rx_st_r <= i_rxd ? SBC_ST_IDLE : SBC_ST_DATA;
            rx_tick_r <= 4'h0;
            rx_idx_r <= 3'h0;
            rx_data_r <= 8'h00;
            rx_zero_r <= 1'b1;
          end
        SBC_ST_DATA:
          if (rx_mid)
          begin
            rx_data_r[rx_idx_r] <= i_rxd;
            rx_zero_r <= rx_zero_r & ~i_rxd;
            rx_idx_r <= rx_idx_r + 3'h1;
            if (rx_idx_r == sbc_last_idx(cfg.len_code))
            begin
              rx_st_r <= cfg.par_en ? SBC_ST_PAR : SBC_ST_STOP;
              rx_stop2_r <= cfg.two_stop;
            end
          end
        SBC_ST_PAR:
          if (rx_mid)
          begin
            rx_par_r <= i_rxd;
            rx_zero_r <= rx_zero_r & ~i_rxd;
            rx_st_r <= SBC_ST_STOP;
          end
        SBC_ST_STOP:
          if (rx_mid)
          begin
            rx_zero_r <= rx_zero_r & ~i_rxd;
            rx_stop2_r <= 1'b0;
            if (!rx_stop2_r)
              rx_st_r <= SBC_ST_IDLE;
          end
        default:
          rx_st_r <= SBC_ST_IDLE;
      endcase
    end
  end

  // received byte to the loop; break frames deliver no byte
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_rx_byte <= 8'h00;
      o_rx_valid <= 1'b0;
    end
    else
    begin
      o_rx_valid <= rx_fin && !rx_brk;
      if (rx_fin && !rx_brk)
        o_rx_byte <= {rx_data_r[7] | rx_mark, rx_data_r[6:0]};
    end
  end

  // ==========================================================================
  // transmitter
  sbc_state_t tx_st_r;
  logic [3:0] tx_tick_r;
  logic [2:0] tx_idx_r;
  logic [7:0] tx_shift_r;
  logic tx_par_r;
  logic tx_stop2_r;
  logic echo_pend_r;
  logic [7:0] echo_byte_r;
  logic tx_accept;
  logic tx_load;
  logic tx_end;
  logic [7:0] tx_src;

  assign tx_accept = i_tx_valid && o_tx_ready && !echo_pend_r;
  assign tx_load = tx_st_r == SBC_ST_IDLE && !rate_off
                   && (echo_pend_r || tx_accept);
  assign tx_src = echo_pend_r ? echo_byte_r : i_tx_byte;
  assign tx_end = tick && tx_tick_r == SBC_MID_BIT;

  // a new echo request wins over the load that clears the old one
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      echo_pend_r <= 1'b0;
      echo_byte_r <= 8'h00;
    end
    else
    begin
      echo_pend_r <= echo_set | (echo_pend_r & ~tx_load);
      if (echo_set)
        echo_byte_r <= rx_data_r;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_tx_ready <= 1'b0;
    else
      o_tx_ready <= tx_st_r == SBC_ST_IDLE && !tx_load && !echo_pend_r
                    && !echo_set && !rate_off;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || rate_off)
    begin
      tx_st_r <= SBC_ST_IDLE;
      tx_tick_r <= 4'h0;
      tx_idx_r <= 3'h0;
      tx_shift_r <= 8'h00;
      tx_par_r <= 1'b0;
      tx_stop2_r <= 1'b0;
      o_txd <= 1'b1;
    end
    else
    begin
      if (tx_st_r != SBC_ST_IDLE && tick)
        tx_tick_r <= tx_tick_r + 4'h1;
      case (tx_st_r)
        SBC_ST_IDLE:
          if (tx_load)
          begin
            tx_shift_r <= tx_src;
            tx_par_r <= sbc_parity(tx_src, cfg.len_code, cfg.par_sel);
            tx_tick_r <= 4'h0;
            tx_st_r <= SBC_ST_START;
            o_txd <= 1'b0;
          end
        SBC_ST_START:
          if (tx_end)
          begin
            tx_st_r <= SBC_ST_DATA;
            tx_idx_r <= 3'h0;
            o_txd <= tx_shift_r[0];
          end
        SBC_ST_DATA:
          if (tx_end)
          begin
            tx_shift_r <= tx_shift_r >> 1;
            tx_idx_r <= tx_idx_r + 3'h1;
            o_txd <= tx_shift_r[1];
            if (tx_idx_r == sbc_last_idx(cfg.len_code))
            begin
              tx_stop2_r <= cfg.two_stop;
              tx_st_r <= cfg.par_en ? SBC_ST_PAR : SBC_ST_STOP;
              o_txd <= cfg.par_en ? tx_par_r : 1'b1;
            end
          end
        SBC_ST_PAR:
          if (tx_end)
          begin
            tx_st_r <= SBC_ST_STOP;
            o_txd <= 1'b1;
          end
        SBC_ST_STOP:
          if (tx_end)
          begin
            tx_stop2_r <= 1'b0;
            if (!tx_stop2_r)
              tx_st_r <= SBC_ST_IDLE;
          end
        default:
          tx_st_r <= SBC_ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // service requests; a new event wins over a same-cycle clear
  sbc_req_t req_ev;

  assign req_ev.manual = i_manual_request_key && misc_en[SBC_MISC_MANUAL];
  assign req_ev.autodisc = i_autodisconnect
                           && misc_en[SBC_MISC_AUTODISC];
  assign req_ev.brk = rx_fin && rx_brk && misc_en[SBC_MISC_BREAK];

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_req_pending <= '0;
      o_srq <= 1'b0;
    end
    else
    begin
      o_req_pending <= req_ev | (o_req_pending & ~{3{i_srq_clear}});
      o_srq <= master_en && (|o_req_pending);
    end
  end

endmodule : sbc_core

// ===== sbc_core_props.sv
// concurrent checks on the serial bridge config core ports
`timescale 1ns/1ps
module sbc_core_props
  import sbc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // loop side
  input wire logic i_local_mode,
  input wire logic i_rd_req,
  input wire logic [7:0] o_rd_byte,
  input wire logic o_rd_valid,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_rx_valid,
  // requests and serial line
  input wire logic i_manual_request_key,
  input wire logic i_autodisconnect,
  input wire logic i_srq_clear,
  input wire logic o_srq,
  input wire sbc_req_t o_req_pending,
  input wire logic o_txd
);
  // ==========================================================================
  // assertions
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_rd_valid_cause:
    assert property (o_rd_valid |-> $past(i_rd_req && i_local_mode))
    else $error("read valid without a taken request");
  a_rd_byte_offset:
    assert property (o_rd_valid |-> o_rd_byte[7:4] == 4'h3)
    else $error("read byte lacks the ascii offset");
  a_srq_needs_pending:
    assert property (o_srq |-> $past(o_req_pending) != 3'b000)
    else $error("request raised with nothing pending");
  a_manual_cause:
    assert property ($rose(o_req_pending.manual) |-> $past(i_manual_request_key))
    else $error("manual pending without key press");
  a_autodisc_cause:
    assert property ($rose(o_req_pending.autodisc) |-> $past(i_autodisconnect))
    else $error("autodisconnect pending without event");
  a_clear_pending:
    assert property (i_srq_clear && !i_manual_request_key && !i_autodisconnect
      |=> !o_req_pending.manual && !o_req_pending.autodisc)
    else $error("pending bits survive a clear");
  a_tx_accept_start:
    assert property (i_tx_valid && o_tx_ready |=> !o_txd && !o_tx_ready)
    else $error("accepted byte did not start a frame");
  a_start_bit_hold:
    assert property ($fell(o_txd) |=> !o_txd [*8])
    else $error("start bit too short");
  a_ready_in_frame:
    assert property (!o_txd |-> !o_tx_ready)
    else $error("ready while a frame is on the line");
  a_rx_valid_pulse:
    assert property (o_rx_valid |=> !o_rx_valid)
    else $error("receive valid longer than one cycle");
endmodule : sbc_core_props

bind sbc_core sbc_core_props u_props (
  .i_clk_sys(i_clk_sys),
  .i_reset(i_reset),
  .i_local_mode(i_local_mode),
  .i_rd_req(i_rd_req),
  .o_rd_byte(o_rd_byte),
  .o_rd_valid(o_rd_valid),
  .i_tx_valid(i_tx_valid),
  .o_tx_ready(o_tx_ready),
  .o_rx_valid(o_rx_valid),
  .i_manual_request_key(i_manual_request_key),
  .i_autodisconnect(i_autodisconnect),
  .i_srq_clear(i_srq_clear),
  .o_srq(o_srq),
  .o_req_pending(o_req_pending),
  .o_txd(o_txd)
);

// ===== sbc_core_test.sv
// self-checking testbench for the serial bridge config core
`timescale 1ns/1ps
module sbc_core_test
  import sbc_pkg::*;
  ;
  // ==========================================================================
  // signals
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic i_local_mode = 1'b1;
  logic i_wr_start = 1'b0;
  logic i_wr_valid = 1'b0;
  logic [7:0] i_wr_byte = 8'h00;
  logic i_rd_start = 1'b0;
  logic i_rd_req = 1'b0;
  logic i_tx_valid = 1'b0;
  logic [7:0] i_tx_byte = 8'h00;
  logic i_manual_request_key = 1'b0;
  logic i_autodisconnect = 1'b0;
  logic i_srq_clear = 1'b0;
  logic [3:0] frame_bits = 4'h8;
  logic [7:0] o_rd_byte, o_rx_byte;
  logic o_rd_valid, o_tx_ready, o_rx_valid, o_srq, o_txd, rxd, frame_valid;
  logic [11:0] frame;
  sbc_req_t o_req_pending;
  logic [3:0] regs [14];
  logic [3:0] saved [14];
  logic [11:0] rd_q[$], rx_q[$], fr_q[$];
  int fails = 0;
  int comparisons = 0;

  always #10 i_clk_sys = ~i_clk_sys;

  sbc_core u_dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_local_mode(i_local_mode),
    .i_wr_start(i_wr_start), .i_wr_valid(i_wr_valid), .i_wr_byte(i_wr_byte),
    .i_rd_start(i_rd_start), .i_rd_req(i_rd_req), .o_rd_byte(o_rd_byte),
    .o_rd_valid(o_rd_valid), .i_tx_valid(i_tx_valid), .i_tx_byte(i_tx_byte),
    .o_tx_ready(o_tx_ready), .o_rx_byte(o_rx_byte), .o_rx_valid(o_rx_valid),
    .i_manual_request_key(i_manual_request_key),
    .i_autodisconnect(i_autodisconnect), .i_srq_clear(i_srq_clear),
    .o_srq(o_srq), .o_req_pending(o_req_pending), .i_rxd(rxd), .o_txd(o_txd));

  sbc_serial_peer u_peer (
    .i_clk_sys(i_clk_sys), .i_txd(o_txd), .o_rxd(rxd),
    .i_frame_bits(frame_bits), .o_frame(frame), .o_frame_valid(frame_valid));

  // ==========================================================================
  // checking
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [11:0] exp,
                     input logic [11:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic [11:0] pop(ref logic [11:0] q[$]);
    if (q.size() == 0)
      return 12'hfff;
    return q.pop_front();
  endfunction : pop

  always @(posedge i_clk_sys)
  begin
    if (o_rd_valid === 1'b1)
      chk("rd_byte", pop(rd_q), {4'h0, o_rd_byte});
    if (o_rx_valid === 1'b1)
      chk("rx_byte", pop(rx_q), {4'h0, o_rx_byte});
    if (frame_valid === 1'b1)
      chk("tx_frame", pop(fr_q), frame);
  end

  task automatic drain(input int limit);
    int k;
    for (k = 0; k < limit; k++)
    begin
      if (rd_q.size() + rx_q.size() + fr_q.size() == 0)
        return;
      @(posedge i_clk_sys);
    end
    fails++;
    $display("ERROR drain expected 0 seen %0d",
             rd_q.size() + fr_q.size() + rx_q.size());
    test_done();
  endtask : drain

  // ==========================================================================
  // drivers
  task automatic wr(input int n);
    int i;
    @(posedge i_clk_sys);
    i_wr_start <= 1'b1;
    for (i = 0; i < n; i++)
    begin
      @(posedge i_clk_sys);
      i_wr_start <= 1'b0;
      i_wr_valid <= 1'b1;
      i_wr_byte <= {4'h3, (i < 14) ? regs[i] : ~regs[0]};
    end
    @(posedge i_clk_sys);
    i_wr_valid <= 1'b0;
  endtask : wr

  task automatic rd_all();
    int i;
    @(posedge i_clk_sys);
    i_rd_start <= 1'b1;
    for (i = 0; i < 14; i++)
    begin
      @(posedge i_clk_sys);
      i_rd_start <= 1'b0;
      i_rd_req <= 1'b1;
      rd_q.push_back({4'h0, SBC_ASCII_OFFSET | {4'h0, regs[i]}});
    end
    @(posedge i_clk_sys);
    i_rd_req <= 1'b0;
    drain(100);
  endtask : rd_all

  task automatic cfg(input logic [3:0] r0, r2, r6, r7, r8);
    regs = '{default: 4'h0};
    regs[0] = r0;
    regs[2] = r2;
    regs[6] = r6;
    regs[7] = r7;
    regs[8] = r8;
    wr(14);
  endtask : cfg

  // pulse {key, autodisconnect, clear} and check the request outputs
  task automatic evt(input logic [2:0] m, input logic [2:0] pend,
                     input logic srq);
    @(posedge i_clk_sys);
    {i_manual_request_key, i_autodisconnect, i_srq_clear} <= m;
    @(posedge i_clk_sys);
    {i_manual_request_key, i_autodisconnect, i_srq_clear} <= 3'b000;
    repeat (3) @(posedge i_clk_sys);
    chk("req_pending", {9'h0, pend}, {9'h0, o_req_pending});
    chk("srq", {11'h0, srq}, {11'h0, o_srq});
  endtask : evt

  // ==========================================================================
  // main sequence
  initial
  begin
    int k;
    logic [7:0] d;
    void'($urandom(3));
    repeat (5) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    regs = '{default: 4'h0};
    regs[7] = SBC_RATE_RESET;
    rd_all();
    foreach (regs[k]) regs[k] = 4'($urandom);
    wr(15);
    rd_all();
    saved = regs;
    foreach (regs[k]) regs[k] = 4'($urandom);
    @(posedge i_clk_sys);
    i_local_mode <= 1'b0;
    wr(14);
    @(posedge i_clk_sys);
    i_local_mode <= 1'b1;
    regs = saved;
    rd_all();
    // requests: master off, then on
    cfg(4'h0, 4'h7, 4'hf, 4'hf, 4'h3);
    evt(3'b100, 3'b100, 1'b0);
    cfg(4'h8, 4'h7, 4'hf, 4'hf, 4'h3);
    evt(3'b000, 3'b100, 1'b1);
    evt(3'b011, 3'b010, 1'b1);
    evt(3'b001, 3'b000, 1'b0);
    // five bits, odd parity wrong, two stops, marking and echo on
    rx_q.push_back(12'h095);
    fr_q.push_back(12'h0d5);
    u_peer.send(12'h0f5, 8);
    u_peer.send(12'h000, 8);
    evt(3'b000, 3'b001, 1'b1);
    drain(40000);
    // eight bits, no parity, one stop
    frame_bits <= 4'h9;
    cfg(4'h8, 4'h7, 4'h0, 4'hf, 4'h0);
    d = 8'($urandom);
    fr_q.push_back({3'h0, 1'b1, d});
    i_tx_byte <= d;
    i_tx_valid <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(posedge i_clk_sys);
      if (o_tx_ready === 1'b1)
        break;
    end
    i_tx_valid <= 1'b0;
    if (k == 200)
    begin
      fails++;
      $display("ERROR tx_ready expected 1 seen %b", o_tx_ready);
      test_done();
    end
    drain(30000);
    cfg(4'h8, 4'h7, 4'h0, 4'h0, 4'h0);
    @(posedge i_clk_sys);
    i_tx_valid <= 1'b1;
    repeat (20) @(posedge i_clk_sys);
    chk("tx_ready", 12'h000, {11'h0, o_tx_ready});
    chk("txd", 12'h001, {11'h0, o_txd});
    i_tx_valid <= 1'b0;
    test_done();
  end
endmodule : sbc_core_test

// ===== sbc_pkg.sv
// shared constants, types and decode functions of the serial bridge config
package sbc_pkg;

  // ==========================================================================
  // clocking and bit timing
  localparam int unsigned SBC_CLK_HZ = 50_000_000;
  localparam int unsigned SBC_CLK_PERIOD_NS = 20;
  localparam int unsigned SBC_OVERSAMPLE = 16;
  localparam logic [3:0] SBC_MID_START = 4'h7;
  localparam logic [3:0] SBC_MID_BIT = 4'hf;

  // ==========================================================================
  // register file indices and widths
  localparam int unsigned SBC_NREGS = 14;
  localparam logic [3:0] SBC_REG_LAST = 4'hd;
  localparam logic [3:0] SBC_REG_PRIMARY = 4'h0;
  localparam logic [3:0] SBC_REG_MISC = 4'h2;
  localparam logic [3:0] SBC_REG_FRAME = 4'h6;
  localparam logic [3:0] SBC_REG_RATE = 4'h7;
  localparam logic [3:0] SBC_REG_PAREC = 4'h8;

  // ==========================================================================
  // field positions
  localparam int unsigned SBC_MASTER_BIT = 3;
  localparam int unsigned SBC_MISC_MANUAL = 2;
  localparam int unsigned SBC_MISC_AUTODISC = 1;
  localparam int unsigned SBC_MISC_BREAK = 0;
  localparam int unsigned SBC_FRAME_STOP = 3;
  localparam int unsigned SBC_FRAME_LEN_HI = 2;
  localparam int unsigned SBC_FRAME_LEN_LO = 1;
  localparam int unsigned SBC_FRAME_MARK = 0;
  localparam int unsigned SBC_PAREC_SEL_HI = 3;
  localparam int unsigned SBC_PAREC_SEL_LO = 2;
  localparam int unsigned SBC_PAREC_PRESENT = 1;
  localparam int unsigned SBC_PAREC_ECHO = 0;

  // ==========================================================================
  // reset values and loop byte coding
  localparam logic [3:0] SBC_RATE_RESET = 4'he;
  localparam logic [3:0] SBC_REG_RESET = 4'h0;
  localparam logic [3:0] SBC_RATE_OFF = 4'h0;
  localparam logic [7:0] SBC_ASCII_OFFSET = 8'h30;

  // ==========================================================================
  // types
  typedef struct packed {
    logic two_stop;
    logic [1:0] len_code;
    logic mark_perr;
    logic [1:0] par_sel;
    logic par_en;
    logic echo;
  } sbc_frame_cfg_t;

  typedef struct packed {
    logic manual;
    logic autodisc;
    logic brk;
  } sbc_req_t;

  typedef enum logic [4:0] {
    SBC_ST_IDLE = 5'b00001,
    SBC_ST_START = 5'b00010,
    SBC_ST_DATA = 5'b00100,
    SBC_ST_PAR = 5'b01000,
    SBC_ST_STOP = 5'b10000
  } sbc_state_t;

  // ==========================================================================
  // functions
  function automatic int unsigned sbc_bps(input int unsigned idx);
    case (idx)
      1: return 50;
      2: return 75;
      3: return 110;
      4: return 135;
      5: return 150;
      6: return 300;
      7: return 600;
      8: return 1200;
      9: return 1800;
      10: return 2400;
      11: return 3600;
      12: return 4800;
      13: return 7200;
      14: return 9600;
      15: return 19200;
      default: return 0;
    endcase
  endfunction : sbc_bps

  function automatic logic [15:0] sbc_divisor(input int unsigned idx);
    int unsigned bps;
    bps = sbc_bps(idx);
    if (bps == 0)
      return 16'h0000;
    return 16'(SBC_CLK_HZ / (SBC_OVERSAMPLE * bps));
  endfunction : sbc_divisor

  // data bits per character: 00 eight, 01 seven, 10 six, 11 five
  function automatic logic [2:0] sbc_last_idx(input logic [1:0] len_code);
    return 3'h7 - {1'b0, len_code};
  endfunction : sbc_last_idx

  // parity over the active data bits: 00 odd, 01 even, 10 one, 11 zero
  function automatic logic sbc_parity(input logic [7:0] data,
                                      input logic [1:0] len_code,
                                      input logic [1:0] sel);
    logic [7:0] mask;
    mask = 8'hff >> len_code;
    case (sel)
      2'b00: return ~^(data & mask);
      2'b01: return ^(data & mask);
      2'b10: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : sbc_parity

endpackage : sbc_pkg

// ===== sbc_serial_peer.sv
// behavioural remote serial device facing the bridge serial pins
`timescale 1ns/1ps
module sbc_serial_peer
  import sbc_pkg::*;
#(
  parameter int BIT_CYC = 2592
)
(
  // clock
  input wire logic i_clk_sys,
  // serial lines
  input wire logic i_txd,
  output logic o_rxd,
  // captured frame
  input wire logic [3:0] i_frame_bits,
  output logic [11:0] o_frame,
  output logic o_frame_valid
);
  initial
  begin
    o_rxd = 1'b1;
    o_frame = 12'h000;
    o_frame_valid = 1'b0;
  end

  // start bit, then n bits lsb first, then idle mark
  task automatic send(input logic [11:0] bits, input int n);
    int i;
    @(posedge i_clk_sys);
    o_rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge i_clk_sys);
    for (i = 0; i < n; i++)
    begin
      o_rxd <= bits[i];
      repeat (BIT_CYC) @(posedge i_clk_sys);
    end
    o_rxd <= 1'b1;
  endtask : send

  // sample each transmitted frame at bit centres
  always
  begin
    logic [11:0] cap;
    @(negedge i_txd);
    cap = 12'h000;
    repeat (BIT_CYC / 2) @(posedge i_clk_sys);
    for (int i = 0; i < 12; i++)
    begin
      if (i < int'(i_frame_bits))
      begin
        repeat (BIT_CYC) @(posedge i_clk_sys);
        cap[i] = i_txd;
      end
    end
    o_frame <= cap;
    o_frame_valid <= 1'b1;
    @(posedge i_clk_sys);
    o_frame_valid <= 1'b0;
  end
endmodule : sbc_serial_peer
